// ===== pkg/sloop_pkg.sv
// shared constants and types for the test loopback switch
package sloop_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [3:0] OFS_CMD = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_CONFIG = 4'h8;
   localparam int CMD_ARG_POS = 8;
   // ==========================================================
   // command codes, written to OFS_CMD bits 7:0
   localparam logic [7:0] CMD_CLEAR_ALL = 8'h01;
   localparam logic [7:0] CMD_SYS_LOOP1 = 8'h02;
   localparam logic [7:0] CMD_SYS_LOOP2 = 8'h03;
   localparam logic [7:0] CMD_LINE_LOOP1 = 8'h04;
   localparam logic [7:0] CMD_LINE_LOOP2 = 8'h05;
   localparam logic [7:0] CMD_MAP_STRAIGHT = 8'h06;
   localparam logic [7:0] CMD_MAP_SWAP = 8'h07;
   localparam logic [7:0] CMD_B1_ON = 8'h08;
   localparam logic [7:0] CMD_B2_ON = 8'h09;
   localparam logic [7:0] CMD_B1_OFF = 8'h0A;
   localparam logic [7:0] CMD_B2_OFF = 8'h0B;
   localparam logic [7:0] CMD_MODE_NTA = 8'h10;
   localparam logic [7:0] CMD_MODE_NTF = 8'h11;
   localparam logic [7:0] CMD_MODE_TEM = 8'h12;
   localparam logic [7:0] CMD_MODE_TES = 8'h13;
   localparam logic [7:0] CMD_POWER_UP = 8'h20;
   localparam logic [7:0] CMD_POWER_DOWN = 8'h21;
   localparam logic [7:0] CMD_ACT_REQUEST = 8'h22;
   localparam logic [7:0] CMD_MONITOR = 8'h23;
   // ==========================================================
   // framing: B1 (8), B2 (8), D (2) per frame, first bit is MSB
   localparam logic [4:0] FRAME_LAST = 5'h11;
   localparam logic [7:0] IDLE_B = 8'hFF;
   localparam logic [1:0] IDLE_D = 2'h3;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      MODE_NTA = 2'h0,
      MODE_NTF = 2'h1,
      MODE_TEM = 2'h2,
      MODE_TES = 2'h3
   } mode_t;
   typedef enum logic [4:0] {
      ACT_OFF = 5'h01,
      ACT_UP = 5'h02,
      ACT_PEND = 5'h04,
      ACT_REQ = 5'h08,
      ACT_ON = 5'h10
   } act_t;
   typedef struct packed {
      logic [7:0] b1;
      logic [7:0] b2;
      logic [1:0] d;
   } frame_t;
   typedef struct packed {
      logic sys_loop_first_bchan;
      logic sys_loop_second_bchan;
      logic line_loop_first_bchan;
      logic line_loop_second_bchan;
      logic bchan_swap_map;
      logic first_bchan_on;
      logic second_bchan_on;
   } loop_cfg_t;
   localparam loop_cfg_t CFG_RST = 7'h00;
   localparam mode_t MODE_RST = MODE_NTA;
   localparam frame_t FRAME_IDLE = 18'h3FFFF;
endpackage

// ===== design/sloop_switch.sv
// loopback and channel routing switch between serial system port and line port
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
module sloop_switch
   import sloop_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // avalon-mm register slave
   input wire logic [3:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // system serial port
   input wire logic BIT_CLK_I,
   input wire logic FRAME_SYNC_ONE_I,
   input wire logic FRAME_SYNC_TWO_I,
   input wire logic SYS_TX_DATA_IN_I,
   output logic SYS_RX_DATA_OUT_O,
   // line port
   input wire logic LINE_RX_IN_I,
   output logic LINE_TX_OUT_O,
   output logic LINE_TX_EN_O,
   output logic ACTIVATION_INDICATION_O
);
   // ==========================================================
   // pin synchronisers and bit clock edge
   logic [4:0] meta_r;
   logic [4:0] sync_r;
   logic bclk_d_r;
   wire [4:0] pins = {BIT_CLK_I, FRAME_SYNC_ONE_I, FRAME_SYNC_TWO_I, SYS_TX_DATA_IN_I, LINE_RX_IN_I};
   wire bclk_rise = sync_r[4] & ~bclk_d_r;
   wire fs_one = sync_r[3];
   wire fs_two = sync_r[2];
   wire sys_bit = sync_r[1];
   wire line_bit = sync_r[0];

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         meta_r <= 5'h00;
         sync_r <= 5'h00;
         bclk_d_r <= 1'b0;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
         bclk_d_r <= sync_r[4];
      end
   end

   // ==========================================================
   // slot counter and frame capture
   logic [4:0] bit_cnt_r;
   logic [16:0] sys_sh_r;
   logic [16:0] line_sh_r;
   frame_t sys_out_r;
   frame_t line_out_r;
   wire [4:0] cnt_inc = (bit_cnt_r == FRAME_LAST) ? 5'h00 : 5'(bit_cnt_r + 5'h01);
   wire [4:0] cur_slot = fs_one ? 5'h00 : cnt_inc;
   wire frame_end = bclk_rise & (cur_slot == FRAME_LAST);
   wire frame_t sys_in = {sys_sh_r, sys_bit};
   wire frame_t line_in = {line_sh_r, line_bit};
   wire [4:0] out_idx = 5'(FRAME_LAST - cur_slot);

   // ==========================================================
   // control state
   loop_cfg_t cfg_r;
   loop_cfg_t cfg_nxt;
   mode_t mode_r;
   mode_t mode_nxt;
   act_t act_r;
   act_t act_nxt;
   logic monitor_r;
   logic monitor_nxt;
   logic skew_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic sys_rx_r;
   logic line_tx_r;
   logic line_en_r;
   logic ai_r;

   // ==========================================================
   // bus decode
   wire req = AVS_READ_I | AVS_WRITE_I;
   wire commit = AVS_WRITE_I & ~wait_r & (AVS_ADDRESS_I == OFS_CMD) & AVS_BYTEENABLE_I[0];
   wire [7:0] code = AVS_WRITEDATA_I[7:0];
   wire arg = AVS_WRITEDATA_I[CMD_ARG_POS] & AVS_BYTEENABLE_I[1];
   wire do_clear = commit & (code == CMD_CLEAR_ALL);
   wire net_mode = (mode_r == MODE_NTA) | (mode_r == MODE_NTF);
   wire ai = (act_r == ACT_ON);
   wire [31:0] status = {23'h000000, mode_r, skew_r, monitor_r, act_r};
   wire [31:0] rd_nxt = (AVS_ADDRESS_I == OFS_STATUS) ? status :
                        (AVS_ADDRESS_I == OFS_CONFIG) ? {25'h0000000, cfg_r} : 32'h00000000;

   // ==========================================================
   // command decode: each bit moves only on its own code; CMD_CLEAR_ALL also clears the four loop bits and mode codes clear monitor
   always_comb begin
      cfg_nxt = cfg_r;
      mode_nxt = mode_r;
      monitor_nxt = monitor_r;
      if (commit) begin
         case (code)
            CMD_CLEAR_ALL: begin
               cfg_nxt.sys_loop_first_bchan = 1'b0;
               cfg_nxt.sys_loop_second_bchan = 1'b0;
               cfg_nxt.line_loop_first_bchan = 1'b0;
               cfg_nxt.line_loop_second_bchan = 1'b0;
            end
            CMD_SYS_LOOP1: cfg_nxt.sys_loop_first_bchan = arg;
            CMD_SYS_LOOP2: cfg_nxt.sys_loop_second_bchan = arg;
            CMD_LINE_LOOP1: cfg_nxt.line_loop_first_bchan = arg;
            CMD_LINE_LOOP2: cfg_nxt.line_loop_second_bchan = arg;
            CMD_MAP_STRAIGHT: cfg_nxt.bchan_swap_map = 1'b0;
            CMD_MAP_SWAP: cfg_nxt.bchan_swap_map = 1'b1;
            CMD_B1_ON: cfg_nxt.first_bchan_on = 1'b1;
            CMD_B2_ON: cfg_nxt.second_bchan_on = 1'b1;
            CMD_B1_OFF: cfg_nxt.first_bchan_on = 1'b0;
            CMD_B2_OFF: cfg_nxt.second_bchan_on = 1'b0;
            CMD_MODE_NTA: begin
               mode_nxt = MODE_NTA;
               monitor_nxt = 1'b0;
            end
            CMD_MODE_NTF: begin
               mode_nxt = MODE_NTF;
               monitor_nxt = 1'b0;
            end
            CMD_MODE_TEM: begin
               mode_nxt = MODE_TEM;
               monitor_nxt = 1'b0;
            end
            CMD_MODE_TES: begin
               mode_nxt = MODE_TES;
               monitor_nxt = 1'b0;
            end
            CMD_MONITOR: monitor_nxt = (mode_r == MODE_TEM);
            default: cfg_nxt = cfg_r;
         endcase
      end
   end

   // ==========================================================
   // activation sequence, one step per frame once requested
   always_comb begin
      act_nxt = act_r;
      case (act_r)
         ACT_OFF: if (commit && code == CMD_POWER_UP) act_nxt = ACT_UP;
         ACT_UP: begin
            if (commit && code == CMD_ACT_REQUEST && net_mode) begin
               act_nxt = ACT_PEND;
            end else if (monitor_r && frame_end) begin
               act_nxt = ACT_PEND;
            end
         end
         ACT_PEND: if (frame_end) act_nxt = ACT_REQ;
         ACT_REQ: if (frame_end) act_nxt = ACT_ON;
         ACT_ON: act_nxt = ACT_ON;
         default: act_nxt = ACT_OFF;
      endcase
      if (commit && code == CMD_POWER_DOWN) act_nxt = ACT_OFF;
   end

   // ==========================================================
   // switch matrix
   function automatic logic [7:0] gate_b(input logic pass, input logic [7:0] data);
      return pass ? data : IDLE_B;
   endfunction

   wire swap = cfg_r.bchan_swap_map;
   wire en1 = cfg_r.first_bchan_on;
   wire en2 = cfg_r.second_bchan_on;
   // line B1/B2 belong to system channel swap?2:1 / swap?1:2
   wire l1_en = swap ? en2 : en1;
   wire l2_en = swap ? en1 : en2;
   wire [7:0] sys_for_l1 = swap ? sys_in.b2 : sys_in.b1;
   wire [7:0] sys_for_l2 = swap ? sys_in.b1 : sys_in.b2;
   wire [7:0] line_for_s1 = swap ? line_in.b2 : line_in.b1;
   wire [7:0] line_for_s2 = swap ? line_in.b1 : line_in.b2;
   wire [7:0] s1_nxt = cfg_r.sys_loop_first_bchan ? gate_b(en1, sys_in.b1) : gate_b(ai & en1, line_for_s1);
   wire [7:0] s2_nxt = cfg_r.sys_loop_second_bchan ? gate_b(en2, sys_in.b2) : gate_b(ai & en2, line_for_s2);
   wire [7:0] l1_nxt = gate_b(ai & l1_en, cfg_r.line_loop_first_bchan ? line_in.b1 : sys_for_l1);
   wire [7:0] l2_nxt = gate_b(ai & l2_en, cfg_r.line_loop_second_bchan ? line_in.b2 : sys_for_l2);
   wire [1:0] sd_nxt = ai ? line_in.d : IDLE_D;
   wire [1:0] ld_nxt = ai ? sys_in.d : IDLE_D;
   wire frame_t sys_frame_nxt = {s1_nxt, s2_nxt, sd_nxt};
   wire frame_t line_frame_nxt = monitor_r ? FRAME_IDLE : {l1_nxt, l2_nxt, ld_nxt};

   // ==========================================================
   // registers
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cfg_r <= CFG_RST;
         mode_r <= MODE_RST;
         act_r <= ACT_OFF;
         monitor_r <= 1'b0;
         skew_r <= 1'b0;
         wait_r <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         cfg_r <= cfg_nxt;
         mode_r <= mode_nxt;
         act_r <= act_nxt;
         monitor_r <= monitor_nxt;
         skew_r <= (bclk_rise & (fs_one != fs_two)) | (skew_r & ~do_clear);
         wait_r <= ~(req & wait_r);
         if (req & wait_r) rdata_r <= rd_nxt;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bit_cnt_r <= FRAME_LAST;
         sys_sh_r <= 17'h1FFFF;
         line_sh_r <= 17'h1FFFF;
         sys_out_r <= FRAME_IDLE;
         line_out_r <= FRAME_IDLE;
         sys_rx_r <= 1'b1;
         line_tx_r <= 1'b1;
      end else if (bclk_rise) begin
         bit_cnt_r <= cur_slot;
         sys_sh_r <= {sys_sh_r[15:0], sys_bit};
         line_sh_r <= {line_sh_r[15:0], line_bit};
         sys_rx_r <= sys_out_r[out_idx];
         line_tx_r <= line_out_r[out_idx];
         if (frame_end) begin
            sys_out_r <= sys_frame_nxt;
            line_out_r <= line_frame_nxt;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         line_en_r <= 1'b0;
         ai_r <= 1'b0;
      end else begin
         line_en_r <= ~monitor_r & (act_r != ACT_OFF);
         ai_r <= ai;
      end
   end

   assign AVS_READDATA_O = rdata_r;
   assign AVS_WAITREQUEST_O = wait_r;
   assign SYS_RX_DATA_OUT_O = sys_rx_r;
   assign LINE_TX_OUT_O = line_tx_r;
   assign LINE_TX_EN_O = line_en_r;
   assign ACTIVATION_INDICATION_O = ai_r;

   // ==========================================================
   // checks
   logic cmd_seen_r;
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) cmd_seen_r <= 1'b0;
      else if (commit) cmd_seen_r <= 1'b1;
   end

   a_reset_loops_clear: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !cmd_seen_r |-> (cfg_r == CFG_RST)) else $error("loop state not clear before any command");
   a_clear_all_loops: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      do_clear |=> !(cfg_r.sys_loop_first_bchan | cfg_r.sys_loop_second_bchan
                     | cfg_r.line_loop_first_bchan | cfg_r.line_loop_second_bchan))
      else $error("clear-all left a loop set");
   a_own_cmd_only: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $changed(cfg_r.sys_loop_first_bchan) |-> $past(commit && (code == CMD_SYS_LOOP1 || code == CMD_CLEAR_ALL)))
      else $error("system loop one changed without its command");
   a_sys_loop_one: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      frame_end && cfg_r.sys_loop_first_bchan && en1 |=> sys_out_r.b1 == $past(sys_in.b1))
      else $error("system loop one did not return system data");
   a_line_loop_one: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      frame_end && ai && !monitor_r && cfg_r.line_loop_first_bchan && l1_en |=> line_out_r.b1 == $past(line_in.b1))
      else $error("line loop one did not return line data");
   a_d_never_looped: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      frame_end && ai && !monitor_r |=> line_out_r.d == $past(sys_in.d))
      else $error("line D did not come from system side");
   a_gate_inactive: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      frame_end && !ai |=> (line_out_r == FRAME_IDLE) && (sys_out_r.d == IDLE_D))
      else $error("data crossed while not activated");
   a_swap_map_b1: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      frame_end && ai && swap && en1 && !cfg_r.sys_loop_first_bchan |=> sys_out_r.b1 == $past(line_in.b2))
      else $error("swap map did not route line B2 to system B1");
   a_act_steps: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (act_r == ACT_PEND) && frame_end && !commit |=> (act_r == ACT_REQ))
      else $error("pending did not advance to request at frame end");
   a_monitor_tx_off: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      monitor_r [*2] |-> !LINE_TX_EN_O) else $error("transmitter driven in monitor mode");
endmodule // sloop_switch

// ===== verif/sloop_partner.sv
// system-side serial controller and line stimulus for the loopback switch
`timescale 1ns/1ns
module sloop_partner
   import sloop_pkg::*;
(
   // frames to send and frames seen
   input wire frame_t sys_frame_i,
   input wire frame_t line_frame_i,
   output frame_t sys_seen_o,
   output frame_t line_seen_o,
   output int frames_o,
   // serial pins
   output logic bit_clk_o,
   output logic fs_one_o,
   output logic fs_two_o,
   output logic sys_tx_o,
   output logic line_rx_o,
   input wire logic sys_rx_i,
   input wire logic line_tx_i
);
   frame_t sys_acc;
   frame_t line_acc;
   // ==========================================================
   // framing, msb first, sync marks slot 0
   initial begin
      bit_clk_o = 1'b0;
      fs_one_o = 1'b0;
      fs_two_o = 1'b0;
      sys_tx_o = 1'b1;
      line_rx_o = 1'b1;
      frames_o = 0;
      sys_seen_o = FRAME_IDLE;
      line_seen_o = FRAME_IDLE;
      sys_acc = FRAME_IDLE;
      line_acc = FRAME_IDLE;
      #203;
      forever begin
         for (int s = 0; s < 18; s++) begin
            fs_one_o = (s == 0);
            fs_two_o = (s == 0);
            sys_tx_o = sys_frame_i[17 - s];
            line_rx_o = line_frame_i[17 - s];
            #62;
            bit_clk_o = 1'b1;
            #63;
            bit_clk_o = 1'b0;
            sys_acc[17 - s] = sys_rx_i;
            line_acc[17 - s] = line_tx_i;
         end
         sys_seen_o = sys_acc;
         line_seen_o = line_acc;
         frames_o = frames_o + 1;
      end
   end
endmodule // sloop_partner

// ===== verif/test_sloop_switch.sv
// self-checking bench for the loopback switch
`timescale 1ns/1ns
module test_sloop_switch;
   import sloop_pkg::*;
   logic clk, rst_n, rd, wr, waitreq, tx_en, act;
   logic bclk, fs1, fs2, stx, lrx, srx, ltx;
   logic [3:0] addr, be;
   logic [31:0] wdata, rdata, q;
   logic [4:0] last;
   logic [14:0] seq;
   frame_t s, l, sys_seen, line_seen;
   int frames, fails, checks;
   sloop_switch u_sloop_switch (.SYS_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(waitreq), .BIT_CLK_I(bclk), .FRAME_SYNC_ONE_I(fs1), .FRAME_SYNC_TWO_I(fs2),
      .SYS_TX_DATA_IN_I(stx), .SYS_RX_DATA_OUT_O(srx), .LINE_RX_IN_I(lrx), .LINE_TX_OUT_O(ltx),
      .LINE_TX_EN_O(tx_en), .ACTIVATION_INDICATION_O(act));
   sloop_partner u_sloop_partner (.sys_frame_i(s), .line_frame_i(l), .sys_seen_o(sys_seen),
      .line_seen_o(line_seen), .frames_o(frames), .bit_clk_o(bclk), .fs_one_o(fs1), .fs_two_o(fs2),
      .sys_tx_o(stx), .line_rx_o(lrx), .sys_rx_i(srx), .line_tx_i(ltx));
   // ==========================================================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (80000) @(posedge clk);
      fails++;
      close_out();
   end
   // ==========================================================
   // tasks
   task automatic close_out();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      be <= b;
      @(posedge clk);
      while (waitreq !== 1'b0) begin
         @(posedge clk);
         n++;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) chk("bus answer", 0, 1);
   endtask
   task automatic cmd(input logic [7:0] c, input logic a = 1'b0);
      bus(OFS_CMD, 1'b1, {23'h0, a, c}, 4'hF);
   endtask
   task automatic rdr(input logic [3:0] a);
      bus(a, 1'b0, 32'h0, 4'hF);
   endtask
   task automatic chkf(input frame_t es, input frame_t el);
      int t;
      t = frames;
      wait (frames >= t + 3);
      chk("sys rx frame", {14'h0, es}, {14'h0, sys_seen});
      chk("line tx frame", {14'h0, el}, {14'h0, line_seen});
   endtask
   // ==========================================================
   // tests
   initial begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      be = 4'hF;
      s = {8'hA5, 8'h3C, 2'h2};
      l = {8'h96, 8'h5A, 2'h1};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rdr(OFS_CONFIG);
      chk("config", 32'h0, q);
      rdr(OFS_STATUS);
      chk("status", 32'h1, q);
      rdr(4'hC);
      chk("unmapped", 32'h0, q);
      for (int m = 0; m < 4; m++) begin
         cmd(CMD_MODE_NTA + 8'(m));
         rdr(OFS_STATUS);
         chk("mode", m, q[8:7]);
      end
      cmd(CMD_MODE_NTA);
      cmd(CMD_B1_ON);
      cmd(CMD_B2_ON);
      bus(OFS_CMD, 1'b1, {24'h0, CMD_MAP_SWAP}, 4'hE);
      rdr(OFS_CONFIG);
      chk("config", 32'h3, q);
      $display("test reset and config done");
      cmd(CMD_POWER_UP);
      rdr(OFS_STATUS);
      chk("powered", 32'h2, q[4:0]);
      cmd(CMD_ACT_REQUEST);
      last = 5'h02;
      seq = 15'h0;
      for (int k = 0; k < 3000 && last !== ACT_ON; k++) begin
         rdr(OFS_STATUS);
         if (q[4:0] !== last) seq = {seq[9:0], q[4:0]};
         last = q[4:0];
      end
      chk("activation order", {5'h04, 5'h08, 5'h10}, seq);
      chk("activated", 32'h1, act);
      chk("tx enable", 32'h1, tx_en);
      $display("test activation done");
      chkf(l, s);
      cmd(CMD_MAP_SWAP);
      chkf({l.b2, l.b1, l.d}, {s.b2, s.b1, s.d});
      cmd(CMD_MAP_STRAIGHT);
      $display("test mapping done");
      cmd(CMD_SYS_LOOP1, 1'b1);
      chkf({s.b1, l.b2, l.d}, s);
      cmd(CMD_SYS_LOOP2, 1'b1);
      chkf({s.b1, s.b2, l.d}, s);
      rdr(OFS_CONFIG);
      chk("config", 32'h63, q);
      cmd(CMD_SYS_LOOP1, 1'b0);
      chkf({l.b1, s.b2, l.d}, s);
      cmd(CMD_CLEAR_ALL);
      rdr(OFS_CONFIG);
      chk("config", 32'h3, q);
      chkf(l, s);
      $display("test system loops done");
      cmd(CMD_LINE_LOOP1, 1'b1);
      chkf(l, {l.b1, s.b2, s.d});
      cmd(CMD_LINE_LOOP2, 1'b1);
      chkf(l, {l.b1, l.b2, s.d});
      cmd(CMD_SYS_LOOP1, 1'b1);
      chkf({s.b1, l.b2, l.d}, {l.b1, l.b2, s.d});
      cmd(CMD_CLEAR_ALL);
      rdr(OFS_CONFIG);
      chk("config", 32'h3, q);
      $display("test line loops done");
      cmd(CMD_B1_OFF);
      chkf({IDLE_B, l.b2, l.d}, {IDLE_B, s.b2, s.d});
      cmd(CMD_B2_OFF);
      chkf({IDLE_B, IDLE_B, l.d}, {IDLE_B, IDLE_B, s.d});
      cmd(CMD_B1_ON);
      cmd(CMD_B2_ON);
      cmd(CMD_POWER_DOWN);
      cmd(CMD_SYS_LOOP1, 1'b1);
      chkf({s.b1, IDLE_B, IDLE_D}, FRAME_IDLE);
      chk("activated", 32'h0, act);
      cmd(CMD_CLEAR_ALL);
      $display("test enables done");
      cmd(CMD_MODE_TEM);
      cmd(CMD_POWER_UP);
      cmd(CMD_MONITOR);
      chkf(FRAME_IDLE, FRAME_IDLE);
      chkf(l, FRAME_IDLE);
      rdr(OFS_STATUS);
      chk("monitor", 32'h1, q[5]);
      chk("sync skew", 32'h0, q[6]);
      chk("activated", 32'h1, act);
      chk("tx enable", 32'h0, tx_en);
      $display("test monitor done");
      close_out();
   end
endmodule // test_sloop_switch
